// file: core/sclp_defines.vh
// constants for the solenoid current loop pwm block: register offsets,
// field positions, reset values and timing counts.
// assumes a 125 MHz core clock and a plain strobe register port.
// Notes on behaviour
// - one mode bit selects fixed or variable
// - fixed mode switches at exactly programmed period
// - variable mode: period is only frequency target
// - fixed: error, p and i, sum versus ramp
// - fixed: integral clamped to ramp range automatically
// - fixed: off when pi falls through ramp
// - fixed: period start resets ramp, driver on
// - gains are two to the exponent fields
// - variable: integrate current and period errors
// - variable: off when integral falls through fi
// - variable: on when integral rises through zero
// - transient on setpoint change or long period
// - threshold 2.5/4.5/8.5/16.5 target periods
// - transient clamps integral to user limits
// - limits are plus/minus two to sel-1
// - transient loads fi from start select
// - frequency gain is two to exponent
// - chopper compensation on unless disable bit set
// - stagger 0/90/180/270 degrees once on target
// - stagger only for fixed frequency channels
// - period code decode with clamp
// - 13-bit setpoint is the regulation target
`ifndef SCLP_DEFINES_VH
`define SCLP_DEFINES_VH

// register index inside a channel window, channel in addr[5:3]
`define SCLP_REG_CTRL 3'h0
`define SCLP_REG_SETPT 3'h1
`define SCLP_REG_GAIN 3'h2
`define SCLP_REG_FREQ 3'h3
`define SCLP_REG_LIMIT 3'h4
`define SCLP_REG_CONF1 3'h5
`define SCLP_REG_STAT 3'h6
`define SCLP_GLOBAL_CH 3'h7
`define SCLP_REG_SERV 3'h0

// control_config_reg fields
`define SCLP_PER_MSB 10
`define SCLP_MODE_BIT 11
`define SCLP_TT_LSB 14
// setpoint register fields
`define SCLP_SP_MSB 12
`define SCLP_AUTO_BIT 15
// channel_config_one fields
`define SCLP_EN_BIT 0
`define SCLP_CHOP_DIS_BIT 14
// service_enable_reg fields
`define SCLP_STAG_BIT 0

`define SCLP_RST_REG 16'h0000

// timing: period grid of 5 us
`define SCLP_TICK_NS 5000
`define SCLP_CLK_MHZ 125
`define SCLP_TICK_CYC ((`SCLP_TICK_NS * `SCLP_CLK_MHZ) / 1000)
`define SCLP_SHORT_BASE 12'h00A
`define SCLP_SHORT_LIMIT 11'h00A
`define SCLP_PER_CLAMP 12'hD06
`define SCLP_TARGET_TOL 14'h0010

`endif

// file: core/sclp_fixed_loop.v
// fixed frequency pi stage with automatic integral limiter.
// assumes ramp and span in 5 us ticks and a one-cycle tick strobe.
`timescale 1ns/1ps
module sclp_fixed_loop (
    input wire clk_in,
    input wire rst_in,
    input wire run_in,
    input wire tick_in,
    input wire start_in,
    input wire signed [13:0] err_in,
    input wire [3:0] kp_in,
    input wire [3:0] ki_in,
    input wire [11:0] span_in,
    input wire [11:0] ramp_in,
    output reg gate_out
);
    reg signed [31:0] integ;
    reg above;
    wire signed [31:0] err_w;
    wire signed [31:0] prop;
    wire signed [31:0] raw;
    wire signed [31:0] hi;
    wire signed [31:0] lo;
    wire signed [31:0] next_integ;
    wire signed [31:0] pi;
    wire now_above;

    // gains are pure shifts
    assign err_w = {{18{err_in[13]}}, err_in};
    assign prop = err_w <<< kp_in;
    assign raw = integ + (err_w <<< ki_in);
    // keep p+i inside the ramp span so the loop never winds up
    assign hi = $signed({20'h00000, span_in}) - prop;
    assign lo = -prop;
    assign next_integ = (raw > hi) ? hi : ((raw < lo) ? lo : raw);
    assign pi = prop + integ;
    assign now_above = (pi >= $signed({20'h00000, ramp_in}));

    // integral steps once per tick; gate set at period start
    always @(posedge clk_in)
    begin
        if (rst_in || !run_in)
        begin
            integ <= 32'sh00000000;
            gate_out <= 1'b0;
            above <= 1'b1;
        end
        else
        begin
            if (tick_in)
                integ <= next_integ;
            above <= now_above;
            if (start_in)
                gate_out <= 1'b1;
            else if (above && !now_above)
                gate_out <= 1'b0;
        end
    end
endmodule

// file: core/sclp_var_loop.v
// variable frequency zero-crossing integrator pair.
// assumes the top measures the period and drives transient and limits.
`timescale 1ns/1ps
module sclp_var_loop (
    input wire clk_in,
    input wire rst_in,
    input wire run_in,
    input wire tick_in,
    input wire transient_in,
    input wire signed [13:0] err_in,
    input wire [3:0] ki_in,
    input wire [3:0] kfi_in,
    input wire signed [31:0] pos_lim_in,
    input wire signed [31:0] neg_lim_in,
    input wire signed [31:0] fi_start_in,
    input wire signed [31:0] per_err_in,
    output wire on_evt_out,
    output reg gate_out
);
    reg signed [31:0] ci;
    reg signed [31:0] ci_prev;
    reg signed [31:0] fi;
    wire signed [31:0] raw;
    wire signed [31:0] next_ci;
    wire off_evt;

    assign raw = ci + ({{18{err_in[13]}}, err_in} <<< ki_in);
    // user limits apply only in transient, never derived
    assign next_ci = !transient_in ? raw :
        ((raw > pos_lim_in) ? pos_lim_in :
        ((raw < neg_lim_in) ? neg_lim_in : raw));
    // edges of the integral against zero and fi; zero counts as below,
    // else a loop that starts at zero with a positive error never fires
    assign on_evt_out = run_in && !gate_out && (ci_prev <= 0) && (ci > 0);
    assign off_evt = gate_out && (ci_prev >= fi) && (ci < fi);

    always @(posedge clk_in)
    begin
        if (rst_in || !run_in)
        begin
            ci <= 32'sh00000000;
            ci_prev <= 32'sh00000000;
            fi <= 32'sh00000000;
            gate_out <= 1'b0;
        end
        else
        begin
            ci_prev <= ci;
            if (tick_in)
                ci <= next_ci;
            if (transient_in)
                fi <= fi_start_in;
            else if (on_evt_out)
                fi <= fi + (per_err_in <<< kfi_in);
            if (on_evt_out)
                gate_out <= 1'b1;
            else if (off_evt)
                gate_out <= 1'b0;
        end
    end
endmodule

// file: core/sclp_top.v
// four-channel solenoid current loop pwm core with register port.
// assumes measured currents arrive on clk_in from the sense logic,
// and a master with one-cycle write and read strobes.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "sclp_defines.vh"
module sclp_top (
    input wire clk_in,
    input wire rst_in,
    input wire [5:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rdata_out,
    input wire [12:0] meas0_in,
    input wire [12:0] meas1_in,
    input wire [12:0] meas2_in,
    input wire [12:0] meas3_in,
    output wire [3:0] gate_out,
    output wire [3:0] chop_en_out
);
    // period code to 5 us ticks, clamped at the longest period
    function [11:0] sclp_period_ticks;
        input [10:0] code;
        reg [11:0] dbl;
        begin
            dbl = {code, 1'b0};
            if (code < `SCLP_SHORT_LIMIT)
                sclp_period_ticks = `SCLP_SHORT_BASE + {1'b0, code};
            else if (dbl > `SCLP_PER_CLAMP)
                sclp_period_ticks = `SCLP_PER_CLAMP;
            else
                sclp_period_ticks = dbl;
        end
    endfunction

    // two to the power sel-1, zero for a zero select
    function signed [31:0] sclp_pow_lim;
        input [4:0] sel;
        begin
            if (sel == 5'h00)
                sclp_pow_lim = 32'sh00000000;
            else
                sclp_pow_lim = 32'sh00000001 <<< (sel - 5'h01);
        end
    endfunction

    // one word per channel, only that channel's block writes it; serv is one global word
    reg [15:0] ctrl_cfg [0:3];
    reg [15:0] setpt [0:3];
    reg [15:0] gain [0:3];
    reg [15:0] freq [0:3];
    reg [15:0] limit [0:3];
    reg [15:0] conf1 [0:3];
    reg [15:0] serv;
    reg [15:0] stat_w [0:3];

    // tick prescaler and read word
    reg [9:0] pre_cnt;
    reg tick;
    reg [15:0] next_rdata;

    // address bits [5:3] pick the channel, [2:0] the register
    wire [2:0] ch_sel;
    wire [2:0] reg_sel;
    wire [12:0] meas_w [0:3];
    wire glob_hit;

    assign ch_sel = addr_in[5:3];
    assign reg_sel = addr_in[2:0];
    assign glob_hit = (ch_sel == `SCLP_GLOBAL_CH);
    assign meas_w[0] = meas0_in;
    assign meas_w[1] = meas1_in;
    assign meas_w[2] = meas2_in;
    assign meas_w[3] = meas3_in;

    // shared 5 us tick: one prescaler feeds every channel's timers
    // counting ticks keeps the fixed period timer at 12 bits; meas_per is 16 bits
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pre_cnt <= 10'h000;
            tick <= 1'b0;
        end
        else if (pre_cnt == (`SCLP_TICK_CYC - 1))
        begin
            pre_cnt <= 10'h000;
            tick <= 1'b1;
        end
        else
        begin
            pre_cnt <= pre_cnt + 10'h001;
            tick <= 1'b0;
        end
    end

    // global service register, stagger enable shared by all channels
    // other bits are not kept and read as zero
    always @(posedge clk_in)
    begin
        if (rst_in)
            serv <= `SCLP_RST_REG;
        else if (wr_in && glob_hit && reg_sel == `SCLP_REG_SERV)
            serv <= {15'h0000, wdata_in[`SCLP_STAG_BIT]};
    end

    // read mux; data appear the cycle after the strobe only
    always @*
    begin
        next_rdata = 16'h0000;
        if (glob_hit)
        begin
            if (reg_sel == `SCLP_REG_SERV)
                next_rdata = serv;
        end
        else if (ch_sel[2] == 1'b0)
        begin
            case (reg_sel)
                `SCLP_REG_CTRL: next_rdata = ctrl_cfg[ch_sel[1:0]];
                `SCLP_REG_SETPT: next_rdata = setpt[ch_sel[1:0]];
                `SCLP_REG_GAIN: next_rdata = gain[ch_sel[1:0]];
                `SCLP_REG_FREQ: next_rdata = freq[ch_sel[1:0]];
                `SCLP_REG_LIMIT: next_rdata = limit[ch_sel[1:0]];
                `SCLP_REG_CONF1: next_rdata = conf1[ch_sel[1:0]];
                `SCLP_REG_STAT: next_rdata = stat_w[ch_sel[1:0]];
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    // read data register: zero outside the answer cycle,
    // so a late sample never picks up a stale word
    always @(posedge clk_in)
    begin
        if (rst_in)
            rdata_out <= 16'h0000;
        else if (rd_in)
            rdata_out <= next_rdata;
        else
            rdata_out <= 16'h0000;
    end

    // one complete loop per channel
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : ch
            reg [11:0] timer;
            reg [15:0] meas_per;
            reg transient;
            reg at_target;
            reg ff_start;

            // decode, error and period wires
            wire wr_hit;
            wire enabled;
            wire var_mode;
            wire [11:0] span;
            wire [11:0] offset;
            wire [11:0] quarter;
            wire [11:0] ramp;
            wire [12:0] sp;
            wire signed [13:0] err;
            wire [13:0] err_abs;

            wire [16:0] thr;
            wire [2:0] thr_shift;
            wire long_per;
            wire sp_change;
            wire stag_on;

            wire on_evt;
            wire ff_gate;
            wire vf_gate;

            wire signed [31:0] pos_lim;
            wire signed [31:0] neg_lim;
            wire signed [31:0] fi_start;
            wire signed [31:0] per_err;

            assign wr_hit = wr_in && (ch_sel == g);
            assign enabled = conf1[g][`SCLP_EN_BIT];
            assign var_mode = ctrl_cfg[g][`SCLP_MODE_BIT];
            assign span = sclp_period_ticks(ctrl_cfg[g][`SCLP_PER_MSB:0]);
            assign sp = setpt[g][`SCLP_SP_MSB:0];
            assign err = $signed({1'b0, sp}) - $signed({1'b0, meas_w[g]});
            assign err_abs = err[13] ? (14'h0000 - err) : err;
            assign sp_change = wr_hit && (reg_sel == `SCLP_REG_SETPT) &&
                (wdata_in[`SCLP_SP_MSB:0] != sp);

            // ctrl, gain, freq and limit writes are taken only while the channel is off
            always @(posedge clk_in)
            begin
                if (rst_in)
                begin
                    ctrl_cfg[g] <= `SCLP_RST_REG;
                    setpt[g] <= `SCLP_RST_REG;
                    gain[g] <= `SCLP_RST_REG;
                    freq[g] <= `SCLP_RST_REG;
                    limit[g] <= `SCLP_RST_REG;
                    conf1[g] <= `SCLP_RST_REG;
                end
                else if (wr_hit)
                begin
                    if (reg_sel == `SCLP_REG_SETPT)
                        setpt[g] <= {wdata_in[15], 2'b00, wdata_in[12:0]};
                    else if (reg_sel == `SCLP_REG_CONF1)
                        conf1[g] <= {1'b0, wdata_in[14], 13'h0000,
                            wdata_in[0]};
                    else if (!enabled)
                    begin
                        case (reg_sel)
                            `SCLP_REG_CTRL: ctrl_cfg[g] <=
                                {wdata_in[15:14], 2'b00, wdata_in[11:0]};
                            `SCLP_REG_GAIN: gain[g] <= {8'h00, wdata_in[7:0]};
                            `SCLP_REG_FREQ: freq[g] <=
                                {8'h00, wdata_in[7:4], 1'b0, wdata_in[2:0]};
                            `SCLP_REG_LIMIT: limit[g] <= {3'h0,
                                wdata_in[12:8], 3'h0, wdata_in[4:0]};
                            default: ctrl_cfg[g] <= ctrl_cfg[g];
                        endcase
                    end
                end
            end

            // stagger: switch-on advanced by a quarter period per channel
            assign stag_on = serv[`SCLP_STAG_BIT] && at_target && !var_mode;
            // whole-tick quarter steps; spans not divisible round down
            assign quarter = {2'b00, span[11:2]};
            assign offset = (!stag_on || g == 0) ? 12'h000 :
                ((g == 1) ? (span - quarter) :
                ((g == 2) ? (span - {quarter[10:0], 1'b0}) :
                (span - quarter - {quarter[10:0], 1'b0})));
            assign ramp = (timer >= offset) ? (timer - offset) :
                (timer + span - offset);

            // fixed period timer counts exactly span ticks
            always @(posedge clk_in)
            begin
                if (rst_in || !enabled)
                begin
                    timer <= 12'h000;
                    ff_start <= 1'b0;
                    at_target <= 1'b0;
                end
                else
                begin
                    ff_start <= tick && (ramp == 12'h000);
                    if (tick)
                        timer <= (timer >= span - 12'h001) ? 12'h000 :
                            timer + 12'h001;
                    // judged once per period, at the current minimum
                    if (tick && ramp == 12'h000)
                        at_target <= (err_abs <= `SCLP_TARGET_TOL);
                end
            end

            // long period threshold: span times 2, 4, 8 or 16, plus half
            // 3-bit shift: a 2-bit sum would wrap select 3 to 1.5 periods
            assign thr_shift = {1'b0, ctrl_cfg[g][15:14]} + 3'h1;
            assign thr = ({5'h00, span} << thr_shift) +
                {6'h00, span[11:1]};
            assign long_per = ({1'b0, meas_per} > thr);
            assign per_err = $signed({16'h0000, meas_per}) -
                $signed({20'h00000, span});

            // period as seen by the variable loop, counted in ticks
            always @(posedge clk_in)
            begin
                if (rst_in || !enabled || !var_mode)
                begin
                    meas_per <= 16'h0000;
                    transient <= 1'b0;
                end
                else
                begin
                    if (on_evt)
                        meas_per <= 16'h0000;
                    else if (tick && meas_per != 16'hFFFF)
                        meas_per <= meas_per + 16'h0001;
                    // entry wins over the exit at a switch-on
                    if ((sp_change && setpt[g][`SCLP_AUTO_BIT]) || long_per)
                        transient <= 1'b1;
                    else if (on_evt)
                        transient <= 1'b0;
                end
            end

            // a zero select gives a zero limit
            assign pos_lim = sclp_pow_lim(limit[g][4:0]);
            assign neg_lim = -sclp_pow_lim(limit[g][12:8]);
            assign fi_start = (freq[g][2:0] == 3'h0) ? 32'sh00000000 :
                (neg_lim >>> (3'h7 - freq[g][2:0]));

            // each stage clears itself while not selected
            sclp_fixed_loop u_ff (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .run_in(enabled && !var_mode),
                .tick_in(tick),
                .start_in(ff_start),
                .err_in(err),
                .kp_in(gain[g][3:0]),
                .ki_in(gain[g][7:4]),
                .span_in(span),
                .ramp_in(ramp),
                .gate_out(ff_gate)
            );

            // period is only a target here; actual one floats
            sclp_var_loop u_vf (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .run_in(enabled && var_mode),
                .tick_in(tick),
                .transient_in(transient),
                .err_in(err),
                .ki_in(gain[g][7:4]),
                .kfi_in(freq[g][7:4]),
                .pos_lim_in(pos_lim),
                .neg_lim_in(neg_lim),
                .fi_start_in(fi_start),
                .per_err_in(per_err),
                .on_evt_out(on_evt),
                .gate_out(vf_gate)
            );

            // a zero setpoint holds the driver in recirculation
            assign gate_out[g] = (sp != 13'h0000) &&
                (var_mode ? vf_gate : ff_gate);
            assign chop_en_out[g] = !conf1[g][`SCLP_CHOP_DIS_BIT];

            // status word: gate, mode, transient, on target
            always @*
            begin
                stat_w[g] = {12'h000, at_target, transient, var_mode,
                    gate_out[g]};
            end
        end
    endgenerate
endmodule

// file: tb/sclp_top_assertions.sv
// checker for the current loop core: register port, gates, chopper.
// assumes a bind to sclp_top; it sees only the top module's ports.
`timescale 1ns/1ps
module sclp_top_assertions (
    input wire clk_in,
    input wire rst_in,
    input wire [5:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [15:0] rdata_out,
    input wire [3:0] gate_out,
    input wire [3:0] chop_en_out
);
    wire ch_ok = (addr_in[5:3] < 3'h4);
    wire [1:0] ch = addr_in[4:3];
    wire wr_conf = wr_in && ch_ok && (addr_in[2:0] == 3'h5);
    reg [3:0] spz;
    reg [3:0] en;
    reg [3:0] mode;

    // shadow state; mode moves only while the channel is off
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            spz <= 4'hF;
            en <= 4'h0;
            mode <= 4'h0;
        end
        else if (wr_in && ch_ok)
        begin
            if (addr_in[2:0] == 3'h1)
                spz[ch] <= (wdata_in[12:0] == 13'h0000);
            if (addr_in[2:0] == 3'h5)
                en[ch] <= wdata_in[0];
            if (addr_in[2:0] == 3'h0 && !en[ch])
                mode[ch] <= wdata_in[11];
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_rdata_idle:
        assert property (!rd_in |=> rdata_out == 16'h0000)
        else $error("read data not cleared");
    chk_unmapped_read:
        assert property (rd_in && addr_in[2:0] == 3'h7 |=> rdata_out == 0)
        else $error("unmapped read not zero");
    chk_ctrl_refused:
        assert property (rd_in && ch_ok && addr_in[2:0] == 3'h0
            |=> rdata_out[11] == $past(mode[ch]))
        else $error("mode bit write not refused or lost");
    chk_status_mode:
        assert property (rd_in && ch_ok && addr_in[2:0] == 3'h6
            |=> rdata_out[1] == $past(mode[ch]))
        else $error("status mode bit wrong");
    chk_zero_setpoint:
        assert property ((gate_out & spz) == 4'h0)
        else $error("gate on with zero setpoint");
    chk_chop_write:
        assert property (wr_conf
            |=> chop_en_out[$past(ch)] == !$past(wdata_in[14]))
        else $error("chopper enable not following disable bit");
    chk_chop_hold:
        assert property (!wr_conf |=> $stable(chop_en_out))
        else $error("chopper enable moved without write");
    chk_chop_reset:
        assert property (@(posedge clk_in) disable iff (1'b0)
            rst_in |=> chop_en_out == 4'hF)
        else $error("chopper enable not on after reset");
    chk_gate_reset:
        assert property (@(posedge clk_in) disable iff (1'b0)
            rst_in |=> gate_out == 4'h0)
        else $error("gate on during reset");

    // main scenarios seen
    cover property ($rose(gate_out[0]));
    cover property ($rose(gate_out[3]));
    cover property (wr_conf && wdata_in[14]);
endmodule

// file: tb/sclp_load_model.sv
// solenoid load seen through driver and current sense, four channels.
// assumes gate high means current rises; two counts per clock up, one down.
`timescale 1ns/1ps
module sclp_load_model (
    input wire clk_in,
    input wire rst_in,
    input wire [3:0] gate_in,
    output wire [12:0] meas0_out,
    output wire [12:0] meas1_out,
    output wire [12:0] meas2_out,
    output wire [12:0] meas3_out
);
    reg [12:0] cur [0:3];
    integer i;

    // linear ramps: crude, but rise and decay differ so the loop
    // must really settle rather than sit at half duty by luck
    always @(posedge clk_in)
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            if (rst_in)
                cur[i] <= 13'h0000;
            else if (gate_in[i] && cur[i] < 13'h1FFD)
                cur[i] <= cur[i] + 13'h0002;
            else if (!gate_in[i] && cur[i] != 13'h0000)
                cur[i] <= cur[i] - 13'h0001;
        end
    end

    assign meas0_out = cur[0];
    assign meas1_out = cur[1];
    assign meas2_out = cur[2];
    assign meas3_out = cur[3];
endmodule

// file: tb/testbench.sv
// self-checking bench for the four-channel current loop core.
// assumes the core include path and a load model on the gates.
`timescale 1ns/1ps
`include "sclp_defines.vh"
module testbench;
    reg clk_in;
    reg rst_in;
    reg wr_in;
    reg rd_in;
    reg [5:0] addr_in;
    reg [15:0] wdata_in;
    wire [15:0] rdata_out;
    wire [3:0] gate_out;
    wire [3:0] chop_en_out;
    wire [12:0] m0;
    wire [12:0] m1;
    wire [12:0] m2;
    wire [12:0] m3;
    integer err_count;
    integer checks;
    integer cyc;
    reg [3:0] gate_q;
    reg [3:0] seen_on;
    reg [3:0] seen_off;
    reg [15:0] d;

    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    sclp_top sclp_top_inst (.clk_in(clk_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .meas0_in(m0),
        .meas1_in(m1), .meas2_in(m2), .meas3_in(m3),
        .gate_out(gate_out), .chop_en_out(chop_en_out));
    sclp_load_model sclp_load_model_inst (.clk_in(clk_in),
        .rst_in(rst_in), .gate_in(gate_out), .meas0_out(m0),
        .meas1_out(m1), .meas2_out(m2), .meas3_out(m3));

    // edge history for gate activity; the ceiling cuts a hang short
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        gate_q <= gate_out;
        seen_on <= rst_in ? 4'h0 : seen_on | (gate_out & ~gate_q);
        seen_off <= rst_in ? 4'h0 : seen_off | (~gate_out & gate_q);
        if (cyc == 90000)
        begin
            err_count = err_count + 1;
            $display("BAD %0t run too long", $time);
            tally_and_finish;
        end
    end

    task chk(input [15:0] got, input [15:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
            err_count = err_count + 1;
        if (got !== exp)
            $display("BAD %0t got %h want %h", $time, got, exp);
    end
    endtask

    // one-cycle strobes with a gap so no strobe is set twice at an edge
    task wr(input [5:0] a, input [15:0] v);
    begin
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
    end
    endtask

    task rd(input [5:0] a, output [15:0] v);
    begin
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        v = rdata_out;
        @(posedge clk_in);
    end
    endtask

    task rw(input [5:0] a, input [15:0] v, input [15:0] m);
    begin
        wr(a, v);
        rd(a, d);
        chk(d & m, v & m);
    end
    endtask

    // returns the cycle of the next rising gate edge on channel ch
    task wait_rise(input integer ch, output integer t);
        integer n;
    begin
        n = 0;
        @(posedge clk_in);
        #1;
        while (n < 20000 && !(gate_out[ch] === 1'b1 && gate_q[ch] === 1'b0))
        begin
            @(posedge clk_in);
            #1;
            n = n + 1;
        end
        t = cyc;
        if (n >= 20000)
            chk(16'h0000, 16'h0001);
    end
    endtask

    task t_regs;
    begin
        rw(6'h08, 16'hC805, 16'hC7FF);
        rw(6'h0A, 16'h00A5, 16'h00FF);
        rw(6'h0B, 16'h0073, 16'h00F7);
        rw(6'h0C, 16'h0A05, 16'h1F1F);
        rw(6'h09, 16'h9234, 16'h9FFF);
        rw(6'h0D, 16'h4000, 16'h4001);
        chk({12'h000, chop_en_out}, 16'h000D);
        wr(6'h0D, 16'h0000);
        chk({12'h000, chop_en_out}, 16'h000F);
        rw(6'h38, 16'h0001, 16'h0001);
        wr(6'h38, 16'h0000);
        wr(6'h0E, 16'hFFFF);
        rd(6'h0E, d);
        chk(d & 16'h0002, 16'h0002);
        rd(6'h0F, d);
        chk(d, 16'h0000);
        rd(6'h20, d);
        chk(d, 16'h0000);
        $display("test registers done");
    end
    endtask

    // config writes refused while enabled; setpoint always taken
    task t_refuse;
    begin
        wr(6'h15, 16'h0001);
        wr(6'h10, 16'h0800);
        rd(6'h10, d);
        chk(d & 16'h0800, 16'h0000);
        wr(6'h12, 16'h00FF);
        rd(6'h12, d);
        chk(d & 16'h00FF, 16'h0000);
        rw(6'h11, 16'h0123, 16'h1FFF);
        wr(6'h15, 16'h0000);
        rw(6'h10, 16'h0800, 16'h0800);
        $display("test refusal done");
    end
    endtask

    // rise-to-rise spacing must be the decoded period exactly
    task t_fixed(input [10:0] code);
        integer t0;
        integer t1;
        integer t2;
        integer per;
    begin
        per = (10 + code) * `SCLP_TICK_CYC;
        wr(6'h05, 16'h0000);
        wr(6'h00, {5'h00, code});
        wr(6'h02, 16'h0011);
        wr(6'h01, 16'h07D0);
        wr(6'h05, 16'h0001);
        wait_rise(0, t0);
        wait_rise(0, t0);
        wait_rise(0, t1);
        wait_rise(0, t2);
        chk(16'(t1 - t0), 16'(per));
        chk(16'(t2 - t1), 16'(per));
        wr(6'h05, 16'h0000);
        $display("test fixed period done");
    end
    endtask

    task t_var_start;
    begin
        wr(6'h18, 16'h0800);
        wr(6'h1A, 16'h0011);
        wr(6'h1B, 16'h0013);
        wr(6'h1C, 16'h0A0A);
        wr(6'h19, 16'h83E8);
        wr(6'h1D, 16'h0001);
        rd(6'h1E, d);
        chk(d & 16'h0002, 16'h0002);
    end
    endtask

    task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    initial
    begin
        rst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 6'h00;
        wdata_in = 16'h0000;
        err_count = 0;
        checks = 0;
        cyc = 0;
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        chk({12'h000, chop_en_out}, 16'h000F);
        chk({12'h000, gate_out}, 16'h0000);
        rd(6'h00, d);
        chk(d, 16'h0000);
        $display("test reset done");
        t_regs;
        t_refuse;
        t_var_start;
        t_fixed(11'h000);
        t_fixed(11'h001);
        chk({15'h0000, seen_on[3]}, 16'h0001);
        chk({15'h0000, seen_off[3]}, 16'h0001);
        $display("test variable done");
        tally_and_finish;
    end
endmodule

bind sclp_top sclp_top_assertions sclp_top_assertions_inst (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .gate_out(gate_out),
    .chop_en_out(chop_en_out));
